// File: hw/cmd_pkg.sv
// constants shared by the command interpreter and its media sequencer
package cmd_pkg;
   // ************************************************************
   // register indices on the plain register port
   // ************************************************************
   localparam logic [3:0] REG_ERROR = 4'h1;
   localparam logic [3:0] REG_SECTOR_COUNT = 4'h2;
   localparam logic [3:0] REG_SECTOR_NUMBER = 4'h3;
   localparam logic [3:0] REG_CYL_LOW = 4'h4;
   localparam logic [3:0] REG_CYL_HIGH = 4'h5;
   localparam logic [3:0] REG_DEVICE_HEAD = 4'h6;
   localparam logic [3:0] REG_COMMAND = 4'h7;
   localparam logic [3:0] REG_STATUS = 4'h7;
   localparam logic [3:0] REG_CONFIG = 4'h8;
   localparam logic [3:0] REG_MAX_LBA = 4'h9;
   // ************************************************************
   // opcodes and field positions
   // ************************************************************
   localparam logic [7:0] OP_FLUSH = 8'he7;
   localparam logic [7:0] OP_FLUSH_EXT = 8'hea;
   localparam logic [7:0] OP_FORMAT_TRACK = 8'h50;
   localparam int DH_LBA_BIT = 6;
   localparam int DH_DEV_BIT = 4;
   localparam int ERR_ABT_BIT = 2;
   localparam int ST_BSY_BIT = 7;
   localparam int ST_RDY_BIT = 6;
   localparam int ST_DF_BIT = 5;
   localparam int ST_DSC_BIT = 4;
   localparam int ST_DRQ_BIT = 3;
   localparam int ST_ERR_BIT = 0;
   // ************************************************************
   // reset values and geometry
   // ************************************************************
   localparam logic [7:0] STATUS_RESET = 8'h50;
   localparam logic [7:0] ERROR_RESET = 8'h00;
   localparam logic [27:0] MAX_LBA_RESET = 28'hfffffff;
   localparam int SECTORS_PER_TRACK = 63;
   localparam int TABLE_BYTES = 512;
   localparam int MEDIA_WRITE_CYCLES = 4;
   typedef enum logic [1:0] {MEDIA_FLUSH, MEDIA_ZERO_TRACK} media_op_t;
endpackage

// File: hw/media_if.sv
// request and answer signals between interpreter and media sequencer
`timescale 1ns/1ps
`default_nettype none
interface media_if;
   logic start;
   cmd_pkg::media_op_t op;
   logic [27:0] first_lba;
   logic done;
   logic fail;
   logic [27:0] last_lba;
   modport ctrl (output start, output op, output first_lba, input done, input fail, input last_lba);
   modport seq (input start, input op, input first_lba, output done, output fail, output last_lba);
endinterface
`default_nettype wire

// File: hw/media_seq.sv
// sequencer that writes back the cache or zero-fills one track
`timescale 1ns/1ps
`default_nettype none
module media_seq (
   input wire logic clk,
   input wire logic rst_n,
   media_if.seq m,
   input wire logic [7:0] dirty_in,
   output logic cache_clear_out,
   output logic write_req_out,
   output logic write_zero_out,
   output logic [27:0] write_lba_out,
   input wire logic write_ack_in,
   input wire logic write_fail_in,
   input wire logic [5:0] defect_map_in
);
   typedef enum {S_IDLE, S_WRITE, S_DONE} seq_state_t;
   seq_state_t state_q;
   cmd_pkg::media_op_t op_q;
   logic [7:0] pending_q;
   logic [5:0] sector_q;
   logic fail_q;

   // ************************************************************
   // sector walk, 1:1 order, logical block addressing
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
         op_q <= cmd_pkg::MEDIA_FLUSH;
         pending_q <= 8'h00;
         sector_q <= 6'h00;
         fail_q <= 1'b0;
         write_req_out <= 1'b0;
         write_zero_out <= 1'b0;
         write_lba_out <= 28'h0000000;
         cache_clear_out <= 1'b0;
         m.done <= 1'b0;
         m.fail <= 1'b0;
         m.last_lba <= 28'h0000000;
      end else begin
         m.done <= 1'b0;
         cache_clear_out <= 1'b0;
         unique case (state_q)
            S_IDLE: begin
               if (m.start) begin
                  op_q <= m.op;
                  pending_q <= dirty_in;
                  fail_q <= 1'b0;
                  sector_q <= 6'h00;
                  write_lba_out <= m.first_lba - 28'(m.first_lba % cmd_pkg::SECTORS_PER_TRACK);
                  state_q <= S_WRITE;
               end
            end
            S_WRITE: begin
               if (write_req_out) begin
                  if (write_ack_in) begin
                     write_req_out <= 1'b0;
                     fail_q <= fail_q | write_fail_in;
                     if (op_q == cmd_pkg::MEDIA_FLUSH) begin
                        pending_q <= pending_q - 8'h01;
                     end else begin
                        sector_q <= sector_q + 6'h01;
                        write_lba_out <= write_lba_out + 28'h0000001;
                     end
                  end
               end else if (op_q == cmd_pkg::MEDIA_FLUSH) begin
                  if (pending_q == 8'h00) begin
                     state_q <= S_DONE;
                  end else begin
                     write_req_out <= 1'b1;
                     write_zero_out <= 1'b0;
                  end
               end else if (sector_q == 6'(cmd_pkg::SECTORS_PER_TRACK)) begin
                  state_q <= S_DONE;
               end else if (defect_map_in[sector_q % 6]) begin
                  sector_q <= sector_q + 6'h01;
                  write_lba_out <= write_lba_out + 28'h0000001;
               end else begin
                  write_req_out <= 1'b1;
                  write_zero_out <= 1'b1;
               end
            end
            S_DONE: begin
               cache_clear_out <= (op_q == cmd_pkg::MEDIA_FLUSH) && !fail_q;
               m.done <= 1'b1;
               m.fail <= fail_q;
               m.last_lba <= write_lba_out - 28'h0000001;
               state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: hw/cmd_engine.sv
// command interpreter for cache flush and single-track format
`timescale 1ns/1ps
`default_nettype none
module cmd_engine #(
   parameter logic DEVICE_ID = 1'b0,
   parameter int HEADS = 16
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   output logic data_req_out,
   input wire logic data_strobe_in,
   input wire logic [7:0] dirty_count_in,
   output logic cache_clear_out,
   output logic write_req_out,
   output logic write_zero_out,
   output logic [27:0] write_lba_out,
   input wire logic write_ack_in,
   input wire logic write_fail_in,
   input wire logic [5:0] defect_map_in
);
   typedef enum {C_IDLE, C_TABLE, C_MEDIA} cmd_state_t;
   logic rst_s1_q;
   logic rst_q;
   cmd_state_t state_q;
   logic [7:0] error_q, status_q, sect_q, cyl_lo_q, cyl_hi_q, devhead_q, config_q;
   logic [27:0] max_lba_q;
   logic [9:0] table_cnt_q;
   logic [27:0] target_d;
   logic lba_mode;
   media_if m ();

   // ************************************************************
   // reset release
   // ************************************************************
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_s1_q <= 1'b0;
         rst_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_q <= rst_s1_q;
      end
   end

   assign lba_mode = devhead_q[cmd_pkg::DH_LBA_BIT];

   // chs target: cylinder * heads + head, times track length
   function automatic logic [27:0] chs_to_lba(input logic [15:0] cyl, input logic [3:0] head);
      logic [31:0] t;
      t = (32'(cyl) * 32'(HEADS) + 32'(head)) * 32'(cmd_pkg::SECTORS_PER_TRACK);
      return t[27:0];
   endfunction

   always_comb begin
      if (lba_mode) begin
         target_d = {devhead_q[3:0], cyl_hi_q, cyl_lo_q, sect_q};
      end else begin
         target_d = chs_to_lba({cyl_hi_q, cyl_lo_q}, devhead_q[3:0]);
      end
   end

   // ************************************************************
   // command decode and completion
   // ************************************************************
   logic selected;
   assign selected = devhead_q[cmd_pkg::DH_DEV_BIT] == DEVICE_ID;

   always_ff @(posedge clk_in or negedge rst_q) begin
      if (!rst_q) begin
         state_q <= C_IDLE;
         status_q <= cmd_pkg::STATUS_RESET;
         error_q <= cmd_pkg::ERROR_RESET;
         table_cnt_q <= 10'h000;
         data_req_out <= 1'b0;
         m.start <= 1'b0;
         m.op <= cmd_pkg::MEDIA_FLUSH;
         m.first_lba <= 28'h0000000;
      end else begin
         m.start <= 1'b0;
         unique case (state_q)
            C_IDLE: begin
               if (wr_in && addr_in == cmd_pkg::REG_COMMAND && selected) begin
                  error_q <= 8'h00;
                  status_q[cmd_pkg::ST_ERR_BIT] <= 1'b0;
                  status_q[cmd_pkg::ST_BSY_BIT] <= 1'b1;
                  if (wdata_in == cmd_pkg::OP_FLUSH || wdata_in == cmd_pkg::OP_FLUSH_EXT) begin
                     m.op <= cmd_pkg::MEDIA_FLUSH;
                     m.start <= 1'b1;
                     state_q <= C_MEDIA;
                  end else if (wdata_in == cmd_pkg::OP_FORMAT_TRACK) begin
                     if (lba_mode && target_d > max_lba_q) begin
                        error_q[cmd_pkg::ERR_ABT_BIT] <= 1'b1;
                        status_q[cmd_pkg::ST_ERR_BIT] <= 1'b1;
                        status_q[cmd_pkg::ST_BSY_BIT] <= 1'b0;
                     end else begin
                        m.op <= cmd_pkg::MEDIA_ZERO_TRACK;
                        m.first_lba <= target_d;
                        table_cnt_q <= 10'h000;
                        data_req_out <= 1'b1;
                        status_q[cmd_pkg::ST_DRQ_BIT] <= 1'b1;
                        state_q <= C_TABLE;
                     end
                  end else begin
                     error_q[cmd_pkg::ERR_ABT_BIT] <= 1'b1;
                     status_q[cmd_pkg::ST_ERR_BIT] <= 1'b1;
                     status_q[cmd_pkg::ST_BSY_BIT] <= 1'b0;
                  end
               end
            end
            C_TABLE: begin
               if (data_strobe_in) begin
                  table_cnt_q <= table_cnt_q + 10'h001;
                  if (table_cnt_q == 10'(cmd_pkg::TABLE_BYTES - 1)) begin
                     data_req_out <= 1'b0;
                     status_q[cmd_pkg::ST_DRQ_BIT] <= 1'b0;
                     m.start <= 1'b1;
                     state_q <= C_MEDIA;
                  end
               end
            end
            C_MEDIA: begin
               if (m.done) begin
                  status_q[cmd_pkg::ST_BSY_BIT] <= 1'b0;
                  status_q[cmd_pkg::ST_DF_BIT] <= 1'b0;
                  status_q[cmd_pkg::ST_ERR_BIT] <= m.fail;
                  error_q[cmd_pkg::ERR_ABT_BIT] <= m.fail;
                  state_q <= C_IDLE;
               end
            end
            default: state_q <= C_IDLE;
         endcase
      end
   end

   // ************************************************************
   // task-file registers
   // ************************************************************
   always_ff @(posedge clk_in or negedge rst_q) begin
      if (!rst_q) begin
         sect_q <= 8'h00;
         cyl_lo_q <= 8'h00;
         cyl_hi_q <= 8'h00;
         devhead_q <= 8'ha0;
         config_q <= 8'h00;
         max_lba_q <= cmd_pkg::MAX_LBA_RESET;
      end else if (state_q == C_MEDIA && m.done && m.op == cmd_pkg::MEDIA_ZERO_TRACK && lba_mode) begin
         sect_q <= m.last_lba[7:0];
         cyl_lo_q <= m.last_lba[15:8];
         cyl_hi_q <= m.last_lba[23:16];
         devhead_q[3:0] <= m.last_lba[27:24];
      end else if (wr_in && state_q == C_IDLE) begin
         unique case (addr_in)
            cmd_pkg::REG_SECTOR_NUMBER: sect_q <= wdata_in;
            cmd_pkg::REG_CYL_LOW: cyl_lo_q <= wdata_in;
            cmd_pkg::REG_CYL_HIGH: cyl_hi_q <= wdata_in;
            cmd_pkg::REG_DEVICE_HEAD: devhead_q <= wdata_in;
            cmd_pkg::REG_CONFIG: config_q <= wdata_in;
            cmd_pkg::REG_MAX_LBA: max_lba_q <= {wdata_in[3:0], max_lba_q[27:4]};
            default: ;
         endcase
      end
   end

   // read data, one cycle after the strobe; zero when no read
   always_ff @(posedge clk_in or negedge rst_q) begin
      if (!rst_q) begin
         rdata_out <= 8'h00;
      end else if (rd_in) begin
         unique case (addr_in)
            cmd_pkg::REG_ERROR: rdata_out <= error_q;
            cmd_pkg::REG_SECTOR_NUMBER: rdata_out <= sect_q;
            cmd_pkg::REG_CYL_LOW: rdata_out <= cyl_lo_q;
            cmd_pkg::REG_CYL_HIGH: rdata_out <= cyl_hi_q;
            cmd_pkg::REG_DEVICE_HEAD: rdata_out <= devhead_q;
            cmd_pkg::REG_STATUS: rdata_out <= status_q;
            cmd_pkg::REG_CONFIG: rdata_out <= config_q;
            default: rdata_out <= 8'h00;
         endcase
      end else begin
         rdata_out <= 8'h00;
      end
   end

   media_seq u_seq (
      .clk(clk_in),
      .rst_n(rst_q),
      .m(m.seq),
      .dirty_in(dirty_count_in),
      .cache_clear_out(cache_clear_out),
      .write_req_out(write_req_out),
      .write_zero_out(write_zero_out),
      .write_lba_out(write_lba_out),
      .write_ack_in(write_ack_in),
      .write_fail_in(write_fail_in),
      .defect_map_in(defect_map_in)
   );

   // ************************************************************
   // checks
   // ************************************************************
   a_flush_waits_media: assert property (@(posedge clk_in) disable iff (!rst_q)
      (state_q == C_MEDIA && !m.done) |=> status_q[cmd_pkg::ST_BSY_BIT])
      else $error("busy dropped before media done");
   a_abort_out_range: assert property (@(posedge clk_in) disable iff (!rst_q)
      (state_q == C_IDLE && wr_in && addr_in == cmd_pkg::REG_COMMAND && selected
       && wdata_in == cmd_pkg::OP_FORMAT_TRACK && lba_mode && target_d > max_lba_q)
      |=> error_q[cmd_pkg::ERR_ABT_BIT] && status_q[cmd_pkg::ST_ERR_BIT])
      else $error("out-of-range format not aborted");
   a_table_ends_drq: assert property (@(posedge clk_in) disable iff (!rst_q)
      (state_q == C_TABLE && data_strobe_in && table_cnt_q == 10'(cmd_pkg::TABLE_BYTES - 1))
      |=> !data_req_out ##0 m.start)
      else $error("table sector not accepted");
   a_done_clears_bsy: assert property (@(posedge clk_in) disable iff (!rst_q)
      (state_q == C_MEDIA && m.done) |=> !status_q[cmd_pkg::ST_BSY_BIT] && !status_q[cmd_pkg::ST_DF_BIT])
      else $error("completion left busy or fault");
   a_zero_writes: assert property (@(posedge clk_in) disable iff (!rst_q)
      (write_req_out && m.op == cmd_pkg::MEDIA_ZERO_TRACK) |-> write_zero_out)
      else $error("format write not zero");
   a_report_lba: assert property (@(posedge clk_in) disable iff (!rst_q)
      (state_q == C_MEDIA && m.done && m.op == cmd_pkg::MEDIA_ZERO_TRACK && lba_mode)
      |=> sect_q == $past(m.last_lba[7:0]))
      else $error("sector number not reported");
   a_report_cyl: assert property (@(posedge clk_in) disable iff (!rst_q)
      (state_q == C_MEDIA && m.done && m.op == cmd_pkg::MEDIA_ZERO_TRACK && lba_mode)
      |=> {cyl_hi_q, cyl_lo_q} == $past(m.last_lba[23:8]))
      else $error("cylinder bytes not reported");
   a_report_head: assert property (@(posedge clk_in) disable iff (!rst_q)
      (state_q == C_MEDIA && m.done && m.op == cmd_pkg::MEDIA_ZERO_TRACK && lba_mode)
      |=> devhead_q[3:0] == $past(m.last_lba[27:24]))
      else $error("head field not reported");

   // ************************************************************
   // sequencing checks
   // ************************************************************
   a_flush_starts: assert property (@(posedge clk_in) disable iff (!rst_q)
      (state_q == C_IDLE && wr_in && addr_in == cmd_pkg::REG_COMMAND && selected
       && (wdata_in == cmd_pkg::OP_FLUSH || wdata_in == cmd_pkg::OP_FLUSH_EXT))
      |=> m.start && m.op == cmd_pkg::MEDIA_FLUSH && status_q[cmd_pkg::ST_BSY_BIT])
      else $error("flush did not start write-back");
   a_busy_in_media: assert property (@(posedge clk_in) disable iff (!rst_q)
      (state_q == C_MEDIA) |-> status_q[cmd_pkg::ST_BSY_BIT])
      else $error("media work without busy");
   a_clear_good_flush: assert property (@(posedge clk_in) disable iff (!rst_q)
      cache_clear_out |-> state_q == C_MEDIA && m.done && !m.fail && m.op == cmd_pkg::MEDIA_FLUSH)
      else $error("cache cleared outside a good flush");
   a_range_no_write: assert property (@(posedge clk_in) disable iff (!rst_q)
      (state_q == C_IDLE && wr_in && addr_in == cmd_pkg::REG_COMMAND && selected
       && wdata_in == cmd_pkg::OP_FORMAT_TRACK && lba_mode && target_d > max_lba_q)
      |=> !m.start && !data_req_out && state_q == C_IDLE)
      else $error("out-of-range format went on");
   a_unselected_idle: assert property (@(posedge clk_in) disable iff (!rst_q)
      (state_q == C_IDLE && wr_in && addr_in == cmd_pkg::REG_COMMAND && !selected)
      |=> state_q == C_IDLE && $stable(status_q) && $stable(error_q))
      else $error("command for other device executed");
   // track number compared, so a defect skip cannot hide a stray write
   a_one_track: assert property (@(posedge clk_in) disable iff (!rst_q)
      (write_req_out && write_zero_out)
      |-> (write_lba_out / cmd_pkg::SECTORS_PER_TRACK) == (m.first_lba / cmd_pkg::SECTORS_PER_TRACK))
      else $error("zero-fill left the selected track");
   a_table_holds_drq: assert property (@(posedge clk_in) disable iff (!rst_q)
      (state_q == C_TABLE) |-> data_req_out && status_q[cmd_pkg::ST_DRQ_BIT])
      else $error("table phase without data request");
   a_idle_no_drq: assert property (@(posedge clk_in) disable iff (!rst_q)
      (state_q != C_TABLE) |-> !data_req_out)
      else $error("data request outside table phase");
   a_fail_sets_abort: assert property (@(posedge clk_in) disable iff (!rst_q)
      (state_q == C_MEDIA && m.done && m.fail)
      |=> error_q[cmd_pkg::ERR_ABT_BIT] && status_q[cmd_pkg::ST_ERR_BIT])
      else $error("failed command without abort");
endmodule
`default_nettype wire

// File: testbench/media_model.sv
// media and cache stand-in that answers the engine's write requests
`timescale 1ns/1ps
`default_nettype none
module media_model (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic write_req_in,
   input wire logic write_zero_in,
   input wire logic [27:0] write_lba_in,
   input wire logic [3:0] delay_in,
   input wire logic fail_in,
   input wire logic clr_in,
   output logic write_ack_out,
   output logic write_fail_out,
   output logic [7:0] count_out,
   output logic [27:0] first_lba_out,
   output logic [27:0] last_lba_out,
   output logic nonzero_out
);
   logic [3:0] wait_q;
   logic go;
   assign go = !write_ack_out && write_req_in && (wait_q >= delay_in);
   // ************************************************************
   // answer, prompt or slow
   // ************************************************************
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         write_ack_out <= 1'b0;
         wait_q <= 4'h0;
      end else if (write_ack_out) begin
         // request is renewed or dropped at this edge, so skip it
         write_ack_out <= 1'b0;
         wait_q <= 4'h0;
      end else if (go) begin
         write_ack_out <= 1'b1;
      end else if (write_req_in) begin
         wait_q <= wait_q + 4'h1;
      end
   end
   // fail toggles outside the ack cycle so a stale level is never trusted
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         write_fail_out <= 1'b0;
      end else if (go) begin
         write_fail_out <= fail_in;
      end else begin
         write_fail_out <= ~write_fail_out;
      end
   end
   // ************************************************************
   // record what was written
   // ************************************************************
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_out <= 8'h00;
         first_lba_out <= 28'h0000000;
         last_lba_out <= 28'h0000000;
         nonzero_out <= 1'b0;
      end else if (clr_in) begin
         count_out <= 8'h00;
         nonzero_out <= 1'b0;
      end else if (go) begin
         count_out <= count_out + 8'h01;
         if (count_out == 8'h00) begin
            first_lba_out <= write_lba_in;
         end
         last_lba_out <= write_lba_in;
         if (!write_zero_in) begin
            nonzero_out <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the flush and track-format command engine
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp, msg) begin \
   comparisons++; \
   if ((got) !== (exp)) begin \
      num_errors++; \
      $display("mismatch at %0t: %s", $time, msg); \
   end \
end
module testbench;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [3:0] addr_in = 4'h0;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic data_strobe_in = 1'b0;
   logic [7:0] dirty_count_in = 8'h00;
   logic [5:0] defect_map_in = 6'h00;
   logic [3:0] delay = 4'h0;
   logic fail = 1'b0;
   logic clr = 1'b0;
   logic [7:0] rdata_out;
   logic data_req_out, cache_clear_out, write_req_out, write_zero_out, write_ack_in, write_fail_in, nonzero;
   logic [27:0] write_lba_out, first_lba, last_lba;
   logic [7:0] count;
   logic [7:0] rd_q;
   int num_errors = 0;
   int comparisons = 0;
   int taken = 0;
   int clears = 0;
   cmd_engine i_cmd_engine (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .data_req_out(data_req_out),
      .data_strobe_in(data_strobe_in), .dirty_count_in(dirty_count_in), .cache_clear_out(cache_clear_out),
      .write_req_out(write_req_out), .write_zero_out(write_zero_out), .write_lba_out(write_lba_out),
      .write_ack_in(write_ack_in), .write_fail_in(write_fail_in), .defect_map_in(defect_map_in));
   media_model i_media_model (.clk_in(clk_in), .rst_n_in(rst_n_in), .write_req_in(write_req_out),
      .write_zero_in(write_zero_out), .write_lba_in(write_lba_out), .delay_in(delay), .fail_in(fail),
      .clr_in(clr), .write_ack_out(write_ack_in), .write_fail_out(write_fail_in), .count_out(count),
      .first_lba_out(first_lba), .last_lba_out(last_lba), .nonzero_out(nonzero));
   always #5 clk_in = ~clk_in;
   // host sends one table byte per requested cycle
   always @(posedge clk_in) begin
      data_strobe_in <= data_req_out;
      if (data_strobe_in === 1'b1 && data_req_out === 1'b1) taken++;
      if (cache_clear_out === 1'b1) clears++;
   end
   // ************************************************************
   // register port tasks
   // ************************************************************
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 rd_q = rdata_out;
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         reg_rd(cmd_pkg::REG_STATUS);
         n++;
      end while (rd_q[7] !== 1'b0 && n < 3000);
      `CHECK(rd_q[7], 1'b0, "busy never cleared")
      repeat (2) @(posedge clk_in);
   endtask
   task automatic run_cmd(input logic [7:0] dh, input logic [7:0] op, input logic [7:0] dirty);
      @(posedge clk_in);
      dirty_count_in <= dirty;
      clr <= 1'b1;
      @(posedge clk_in);
      clr <= 1'b0;
      taken = 0;
      clears = 0;
      reg_wr(cmd_pkg::REG_DEVICE_HEAD, dh);
      reg_wr(cmd_pkg::REG_COMMAND, op);
   endtask
   task automatic fmt(input logic [27:0] v, input logic [7:0] dh);
      reg_wr(cmd_pkg::REG_SECTOR_NUMBER, v[7:0]);
      reg_wr(cmd_pkg::REG_CYL_LOW, v[15:8]);
      reg_wr(cmd_pkg::REG_CYL_HIGH, v[23:16]);
      run_cmd(dh, cmd_pkg::OP_FORMAT_TRACK, 8'h00);
      wait_idle();
   endtask
   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #400us;
      num_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      finish_test();
   end
   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      logic [27:0] v, st;
      int good;
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      reg_rd(cmd_pkg::REG_STATUS);
      `CHECK(rd_q, cmd_pkg::STATUS_RESET, "status reset value")
      reg_rd(cmd_pkg::REG_ERROR);
      `CHECK(rd_q, cmd_pkg::ERROR_RESET, "error reset value")
      $display("test reset done");
      delay = 4'h3;
      for (int i = 0; i < 2; i++) begin
         run_cmd(8'ha0, (i == 0) ? cmd_pkg::OP_FLUSH : cmd_pkg::OP_FLUSH_EXT, 8'h05);
         reg_rd(cmd_pkg::REG_STATUS);
         `CHECK(rd_q[7], 1'b1, "busy during flush")
         `CHECK(count < 8'h05 && clears == 0, 1'b1, "flush ended early")
         wait_idle();
         `CHECK(count, 8'h05, "flush write count")
         `CHECK(rd_q & 8'ha1, 8'h00, "flush good status")
         `CHECK(clears, 1, "cache clear pulse")
         $display("test flush %0d done", i);
      end
      fail <= 1'b1;
      run_cmd(8'ha0, cmd_pkg::OP_FLUSH_EXT, 8'h02);
      wait_idle();
      fail <= 1'b0;
      `CHECK(rd_q & 8'ha1, 8'h01, "failed flush status")
      `CHECK(clears, 0, "clear after failed flush")
      reg_rd(cmd_pkg::REG_ERROR);
      `CHECK(rd_q, 8'h04, "failed flush error")
      $display("test flush fail done");
      run_cmd(8'hb0, cmd_pkg::OP_FLUSH, 8'h03);
      repeat (30) @(posedge clk_in);
      reg_rd(cmd_pkg::REG_STATUS);
      `CHECK(rd_q[7], 1'b0, "other device busy")
      `CHECK(count, 8'h00, "other device wrote")
      $display("test select done");
      delay = 4'h0;
      @(posedge clk_in);
      defect_map_in <= 6'h21;
      v = 28'h1234567;
      st = v - 28'(v % 28'h3f);
      good = 0;
      fmt(v, {4'he, v[27:24]});
      for (int s = 0; s < cmd_pkg::SECTORS_PER_TRACK; s++) if (!defect_map_in[s % 6]) good++;
      `CHECK(taken, cmd_pkg::TABLE_BYTES, "table bytes taken")
      `CHECK(data_req_out, 1'b0, "table request left up")
      `CHECK(count, 8'(good), "good sectors written")
      `CHECK(first_lba, st + 28'h1, "first zeroed block")
      `CHECK(last_lba, st + 28'h3e, "last zeroed block")
      `CHECK(nonzero, 1'b0, "non-zero write")
      `CHECK(rd_q & 8'ha9, 8'h00, "format status")
      reg_rd(cmd_pkg::REG_SECTOR_NUMBER);
      `CHECK(rd_q, last_lba[7:0], "reported lba 0-7")
      reg_rd(cmd_pkg::REG_CYL_LOW);
      `CHECK(rd_q, last_lba[15:8], "reported lba 8-15")
      reg_rd(cmd_pkg::REG_CYL_HIGH);
      `CHECK(rd_q, last_lba[23:16], "reported lba 16-23")
      reg_rd(cmd_pkg::REG_DEVICE_HEAD);
      `CHECK(rd_q[3:0], last_lba[27:24], "reported lba 24-27")
      $display("test format lba done");
      @(posedge clk_in);
      defect_map_in <= 6'h00;
      fmt(28'h0000201, 8'ha3);
      `CHECK(count, 8'h3f, "chs sectors written")
      `CHECK(first_lba, 28'h000089d, "chs track start")
      `CHECK(last_lba, 28'h00008db, "chs track end")
      $display("test format chs done");
      v = 28'h0000100;
      // each write enters at the top, so the lowest nibble goes first
      for (int k = 0; k < 7; k++) reg_wr(cmd_pkg::REG_MAX_LBA, {4'h0, v[4 * k +: 4]});
      fmt(28'h0001000, 8'he0);
      `CHECK(count, 8'h00, "out of range wrote")
      `CHECK(rd_q[0], 1'b1, "out of range status")
      reg_rd(cmd_pkg::REG_ERROR);
      `CHECK(rd_q, 8'h04, "out of range abort")
      $display("test range done");
      finish_test();
   end
endmodule
`default_nettype wire
